// >>> hdl/pvp_pkg.sv
// pvp_pkg: shared constants, register map and types of the position and
// velocity processing block.
// assumes: a 50 MHz pclk; raw scans arrive at most once per measurement tick.
package pvp_pkg;
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned TICK_US     = 1000;
  localparam int unsigned TICK_CYC    = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned ERR_DLY_MS  = 50;
  localparam int unsigned INT_DEPTH   = 8;
  localparam int unsigned VAVG_LOG2   = 3;
  localparam int unsigned RQ_PCT_MAX  = 100;
  // inch units: one hundredth of an inch is 254 microns
  localparam int unsigned UM_PER_CIN  = 254;

  // register byte offsets
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_OFFSET  = 8'h04;
  localparam logic [7:0] A_PRESET  = 8'h08;
  localparam logic [7:0] A_PRES    = 8'h0C;
  localparam logic [7:0] A_VRES    = 8'h10;
  localparam logic [7:0] A_DEPTH   = 8'h14;
  localparam logic [7:0] A_ERRDLY  = 8'h18;
  localparam logic [7:0] A_ERRVAL  = 8'h1C;
  localparam logic [7:0] A_POS     = 8'h20;
  localparam logic [7:0] A_VEL     = 8'h24;
  localparam logic [7:0] A_QUAL    = 8'h28;
  localparam logic [7:0] A_DIST    = 8'h2C;
  localparam logic [7:0] A_STAT    = 8'h30;
  localparam logic [7:0] A_IRQ_ST  = 8'h34;
  localparam logic [7:0] A_IRQ_EN  = 8'h38;
  localparam logic [7:0] A_IRQ_CLR = 8'h3C;
  localparam logic [7:0] A_CMD     = 8'h40;

  // control bits
  localparam int unsigned C_OFS_EN  = 0;
  localparam int unsigned C_PRE_EN  = 1;
  localparam int unsigned C_INCH    = 2;
  localparam int unsigned C_SERVICE = 3;
  localparam int unsigned C_VAVG    = 4;   // 3 bits, window = 2^(n+1) ms, code 7 clamped to 128 ms

  // interrupt bits
  localparam int unsigned I_NEW     = 0;
  localparam int unsigned I_ERR     = 1;
  localparam int unsigned I_SUBST   = 2;
  localparam int unsigned I_PRESET  = 3;

  localparam logic [31:0] CTRL_RST   = 32'h0000_0020;   // 8 ms averaging
  localparam logic [31:0] PRES_RST   = 32'h0000_03E8;   // 1 mm in um
  localparam logic [31:0] VRES_RST   = 32'h0000_0001;   // 1 mm/s
  localparam logic [31:0] ERRVAL_RST = 32'h0000_0000;

  typedef struct packed {
    logic        valid;
    logic        ok;
    logic [31:0] pos_um;
    logic [6:0]  quality;
    logic [15:0] dist_mm;
  } pvp_scan_t;

  typedef enum logic [2:0] {
    ST_OK    = 3'b001,
    ST_HOLD  = 3'b010,
    ST_SUBST = 3'b100
  } pvp_err_t;
endpackage

// >>> hdl/pvp_core.sv
// pvp_core: averaging, correction, scaling, velocity and error suppression
// for the tape position sensor, with an APB register file.
// assumes: scan words come from the optics pipeline in the pclk domain.
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
// Summary of operation
// (R1) one raw measurement per 1 ms tick
// (R2) average position over configurable depth, default eight
// (R3) offset enabled: output position plus signed offset
// (R4) preset event from input or bus captures reference
// (R5) preset enabled wins over offset
// (R6) resolution scales host value only
// (R7) unit select switches mm and hundredth inch
// (R8) velocity from positions, scaled on bus output
// (R9) velocity averaged over 2 to 128 ms
// (R10) hold last valid value during error delay
// (R11) after delay output substitute error value
// (R12) report read quality percentage
// (R13) service mode reports tape distance
// (R14) velocity once per window from position change integrated each good tick
module pvp_core
  import pvp_pkg::*;
#(
  parameter int unsigned TICK    = pvp_pkg::TICK_CYC,
  parameter int unsigned MAXDEP  = 16
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // measurement stream and switching input
  input  wire pvp_pkg::pvp_scan_t scan,
  input  wire logic             preset_in,
  // results
  output logic                  meas_tick,
  output logic                  irq
);
  import pvp_pkg::*;

  function automatic logic [31:0] sdiv(input logic signed [31:0] v,
                                       input logic [31:0] d);
    sdiv = (d == 32'h0) ? v : 32'(v / $signed({1'b0, d[30:0]}));
  endfunction

  logic [31:0] ctrl_r, ofs_r, preset_r, pres_r, vres_r, depth_r;
  logic [31:0] errdly_r, errval_r, pos_r, vel_r, ien_r;
  logic [3:0]  ist_r;
  logic [6:0]  qual_r;
  logic [15:0] dist_r;
  logic [31:0] tcnt_r;
  logic signed [31:0] hist_r [MAXDEP];
  logic signed [39:0] sum_r;
  logic [4:0]  widx_r;
  logic signed [31:0] last_avg_r, ref_r, vacc_r;
  logic        ref_ok_r, pre_in_d_r;
  logic [7:0]  vcnt_r;
  logic [31:0] ecnt_r;
  pvp_err_t    est_r;

  // apb decode
  wire wr  = psel & penable & pwrite;
  wire rd_ok = (paddr[1:0] == 2'b00) && (paddr <= A_CMD);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~rd_ok;
  wire wr_ok = wr & rd_ok;

  // 1 ms measurement tick [R1]
  wire tick = (tcnt_r == 32'(TICK - 1));
  assign meas_tick = tick;

  wire pre_edge = preset_in & ~pre_in_d_r;
  wire pre_cmd  = wr_ok && paddr == A_CMD && pwdata[0];
  wire pre_evt  = pre_edge | pre_cmd;                  // [R4]

  // integration depth clamp [R2]
  wire [4:0] dep = (depth_r == 32'h0) ? 5'd1 :
                   (depth_r > 32'(MAXDEP)) ? 5'(MAXDEP) : depth_r[4:0];
  wire [4:0] ridx = (widx_r >= dep) ? widx_r - dep : widx_r + 5'(MAXDEP) - dep;
  wire signed [39:0] sum_nxt = sum_r + 40'(signed'(scan.pos_um))
                               - 40'(hist_r[ridx[3:0]]);
  wire signed [31:0] avg = 32'(sum_nxt / $signed({35'h0, dep}));  // [R2]
  wire good = tick & scan.valid & scan.ok;

  // unit conversion [R7]
  wire signed [31:0] avg_u = ctrl_r[C_INCH] ?
                             32'(avg / $signed(32'(UM_PER_CIN))) :
                             32'(avg / 32'sd1000);
  wire signed [31:0] corr  = (ctrl_r[C_PRE_EN] && ref_ok_r) ?
                             avg_u - ref_r + $signed(preset_r) :   // [R5]
                             ctrl_r[C_OFS_EN] ? avg_u + $signed(ofs_r) :
                             avg_u;                                 // [R3]
  // resolution step in microns (or 1/100000 in) [R6]
  wire [31:0] pos_out = sdiv(corr * 1000, pres_r);

  // velocity over 2^(n+1) ms window [R9][R14]
  // code 7 would shift the window to zero; clamp it to 128 ms
  wire [2:0]  vsel = ctrl_r[C_VAVG +: 3];
  wire [7:0]  vwin = (vsel == 3'h7) ? 8'h80 : 8'h02 << vsel;
  wire signed [31:0] dpos = avg - last_avg_r;
  wire signed [31:0] vacc_nxt = vacc_r + dpos;
  wire signed [31:0] vel_ums = 32'(vacc_nxt * 1000 / $signed({24'h0, vwin}));
  wire signed [31:0] vel_u = ctrl_r[C_INCH] ?
                             32'(vel_ums / $signed(32'(UM_PER_CIN))) :
                             32'(vel_ums / 32'sd1000);
  wire [31:0] vel_out = sdiv(vel_u, vres_r);                        // [R8]

  wire err_exp = (ecnt_r >= errdly_r);
  wire [3:0] iclr = (wr_ok && paddr == A_IRQ_CLR) ? pwdata[3:0] : 4'h0;
  wire [3:0] iset = {pre_evt, tick & est_r == ST_HOLD & err_exp,
                     tick & ~good & scan.valid, good};
  assign irq = |(ist_r & ien_r[3:0]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST; ofs_r <= 32'h0; preset_r <= 32'h0;
      pres_r <= PRES_RST; vres_r <= VRES_RST; depth_r <= 32'(INT_DEPTH);
      errdly_r <= 32'(ERR_DLY_MS); errval_r <= ERRVAL_RST;
      ien_r <= 32'h0; ist_r <= 4'h0; pre_in_d_r <= 1'b0;
    end else begin
      pre_in_d_r <= preset_in;
      ist_r <= (ist_r & ~iclr) | iset;           // set wins over clear
      if (wr_ok) begin
        unique case (paddr)
          A_CTRL:   ctrl_r   <= pwdata;
          A_OFFSET: ofs_r    <= pwdata;
          A_PRESET: preset_r <= pwdata;
          A_PRES:   pres_r   <= pwdata;
          A_VRES:   vres_r   <= pwdata;
          A_DEPTH:  depth_r  <= pwdata;
          A_ERRDLY: errdly_r <= pwdata;
          A_ERRVAL: errval_r <= pwdata;
          A_IRQ_EN: ien_r    <= pwdata;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tcnt_r <= 32'h0;
    else tcnt_r <= tick ? 32'h0 : tcnt_r + 32'h1;
  end

  // cleared so the running sum never subtracts an unknown sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < MAXDEP; i++) hist_r[i] <= 32'sh0;
    end else if (good) hist_r[widx_r[3:0]] <= signed'(scan.pos_um);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum_r <= 40'sh0; widx_r <= 5'h0; last_avg_r <= 32'sh0;
      ref_r <= 32'sh0; ref_ok_r <= 1'b0; vacc_r <= 32'sh0; vcnt_r <= 8'h0;
      pos_r <= 32'h0; vel_r <= 32'h0; qual_r <= 7'h0; dist_r <= 16'h0;
      ecnt_r <= 32'h0; est_r <= ST_OK;
    end else begin
      if (pre_evt) begin
        ref_r <= avg_u; ref_ok_r <= 1'b1;                          // [R4]
      end
      if (tick & scan.valid) begin
        qual_r <= (scan.quality > 7'(RQ_PCT_MAX)) ? 7'(RQ_PCT_MAX)
                                                  : scan.quality;  // [R12]
        if (ctrl_r[C_SERVICE]) dist_r <= scan.dist_mm;             // [R13]
      end
      if (good) begin
        sum_r <= sum_nxt;
        widx_r <= (widx_r == 5'(MAXDEP - 1)) ? 5'h0 : widx_r + 5'h1;
        last_avg_r <= avg;
        pos_r <= pos_out;
        if (vcnt_r + 8'h1 >= vwin) begin
          vel_r <= vel_out; vacc_r <= 32'sh0; vcnt_r <= 8'h0;      // [R9]
        end else begin
          vacc_r <= vacc_nxt; vcnt_r <= vcnt_r + 8'h1;
        end
        ecnt_r <= 32'h0;
        est_r <= ST_OK;
      end else if (tick) begin
        unique case (est_r)
          ST_OK: begin
            est_r <= ST_HOLD; ecnt_r <= 32'h1;                     // [R10]
          end
          ST_HOLD: begin
            if (err_exp) begin
              est_r <= ST_SUBST;                                   // [R11]
              pos_r <= errval_r; vel_r <= errval_r;
            end else ecnt_r <= ecnt_r + 32'h1;
          end
          ST_SUBST: ;
          default: est_r <= ST_OK;
        endcase
      end
    end
  end

  always_comb begin
    prdata = 32'h0;
    if (psel && !pwrite && rd_ok) begin
      unique case (paddr)
        A_CTRL:   prdata = ctrl_r;
        A_OFFSET: prdata = ofs_r;
        A_PRESET: prdata = preset_r;
        A_PRES:   prdata = pres_r;
        A_VRES:   prdata = vres_r;
        A_DEPTH:  prdata = depth_r;
        A_ERRDLY: prdata = errdly_r;
        A_ERRVAL: prdata = errval_r;
        A_POS:    prdata = pos_r;
        A_VEL:    prdata = vel_r;
        A_QUAL:   prdata = {25'h0, qual_r};
        A_DIST:   prdata = {16'h0, dist_r};
        A_STAT:   prdata = {29'h0, est_r};
        A_IRQ_ST: prdata = {28'h0, ist_r};
        A_IRQ_EN: prdata = ien_r;
        default:  prdata = 32'h0;
      endcase
    end
  end

  a_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> !tick) else $error("tick not single cycle"); // [R1]
  a_subst_out: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && !good && est_r == ST_HOLD && err_exp) |=>
      (pos_r == errval_r && est_r == ST_SUBST))
    else $error("substitute not output"); // [R11]
  a_hold_value: assert property (@(posedge pclk) disable iff (!presetn)
    (est_r == ST_HOLD && !good && !(tick && err_exp)) |=> $stable(pos_r))
    else $error("held value changed"); // [R10]
  a_preset_ref: assert property (@(posedge pclk) disable iff (!presetn)
    pre_evt |=> ref_ok_r) else $error("preset not captured"); // [R4]
  a_quality_pct: assert property (@(posedge pclk) disable iff (!presetn)
    qual_r <= 7'(RQ_PCT_MAX)) else $error("quality over 100"); // [R12]
  a_ok_after_good: assert property (@(posedge pclk) disable iff (!presetn)
    good |=> est_r == ST_OK) else $error("error state stuck"); // [R10]
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    (ist_r[I_NEW] && ien_r[I_NEW]) |-> irq) else $error("irq missing");
  a_vel_window: assert property (@(posedge pclk) disable iff (!presetn)
    vcnt_r < vwin) else $error("velocity window overrun"); // [R9]
endmodule // pvp_core

// >>> verif/pvp_optics.sv
// pvp_optics: scan source standing in for the optics pipeline.
// assumes: bench sets step, ok, quality and distance; one scan per tick.
`timescale 1ns/100ps
module pvp_optics (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // measurement tick from the core and bench controls
  input  wire logic               meas_tick,
  input  wire logic [31:0]        step,
  input  wire logic               ok,
  input  wire logic [6:0]         quality,
  input  wire logic [15:0]        dist_mm,
  // scan word to the core
  output pvp_pkg::pvp_scan_t      scan
);
  import pvp_pkg::*;
  logic [31:0] pos_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_r <= 32'h004C_4B40;
      scan  <= '0;
    end else if (meas_tick) begin
      pos_r        <= pos_r + step;
      scan.valid   <= 1'b1;
      scan.ok      <= ok;
      // bad read carries junk, never the last good value
      scan.pos_um  <= ok ? pos_r : ~pos_r;
      scan.quality <= quality;
      scan.dist_mm <= dist_mm;
    end
  end
endmodule // pvp_optics

// >>> verif/position_velocity_processing_tb.sv
// position_velocity_processing_tb: self-checking bench of pvp_core.
// assumes: pvp_optics feeds scans; tick shortened to 20 cycles.
`timescale 1ns/100ps
module position_velocity_processing_tb;
  import pvp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, preset_in, ok;
  logic        pready, pslverr, meas_tick, irq, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, step, rv, pv;
  logic [6:0]  quality;
  logic [15:0] dist_mm;
  pvp_scan_t   scan;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          n;
  typedef struct packed {logic [31:0] ctrl, pres, pos;} pvp_row_t;
  localparam pvp_row_t ROWS [4] = '{
    '{32'h0000_0020, 32'h0000_03E8, 32'h0000_1388},
    '{32'h0000_0021, 32'h0000_03E8, 32'h0000_1392},
    '{32'h0000_0020, 32'h0000_2710, 32'h0000_01F4},
    '{32'h0000_0021, 32'h0000_0064, 32'h0000_C3B4}};
  localparam logic [7:0]  RA [7] = '{A_CTRL, A_PRES, A_VRES, A_DEPTH,
    A_ERRDLY, A_ERRVAL, A_IRQ_EN};
  localparam logic [31:0] RV [7] = '{CTRL_RST, PRES_RST, VRES_RST,
    32'h0000_0008, 32'h0000_0032, ERRVAL_RST, 32'h0000_0000};

  pvp_core #(.TICK(20)) uut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .scan, .preset_in,
    .meas_tick, .irq);
  pvp_optics src (.pclk, .presetn, .meas_tick, .step, .ok, .quality,
    .dist_mm, .scan);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rv, e);
  endtask

  // waits for n ticks, returns on the rising edge after the last
  task automatic ticks(input int t);
    int k;
    repeat (t) begin
      k = 0;
      do begin
        @(negedge pclk);
        k++;
      end while (meas_tick !== 1'b1 && k < 100);
    end
    @(posedge pclk);
  endtask

  initial begin
    #1_000_000;
    num_errors++;
    test_done();
  end

  initial begin
    {presetn, psel, penable, pwrite, preset_in} = 5'h00;
    {paddr, pwdata, step} = '0;
    ok = 1'b1;
    quality = 7'h5A;
    dist_mm = 16'h0078;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    ticks(1);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (meas_tick !== 1'b1 && n < 100);
    chk("tick period", n, 20);
    apb(1'b1, A_OFFSET, 32'h0000_000A);
    ticks(10);
    foreach (ROWS[i]) begin
      apb(1'b1, A_CTRL, ROWS[i].ctrl);
      apb(1'b1, A_PRES, ROWS[i].pres);
      ticks(3);
      rdc("pos", A_POS, ROWS[i].pos);
    end
    rdc("offset", A_OFFSET, 32'h0000_000A);
    apb(1'b1, A_POS, 32'h0000_0000);
    rdc("pos ro", A_POS, 32'h0000_C3B4);
    apb(1'b1, 8'h44, 32'h0000_0001);
    chk("slverr", {31'h0, err}, 32'h0000_0001);
    // preset from the switching input, then from a bus command
    apb(1'b1, A_PRES, 32'h0000_03E8);
    apb(1'b1, A_PRESET, 32'h0000_0064);
    apb(1'b1, A_CTRL, 32'h0000_0023);
    preset_in <= 1'b1;
    ticks(3);
    rdc("preset in", A_POS, 32'h0000_0064);
    apb(1'b1, A_PRESET, 32'h0000_00C8);
    apb(1'b1, A_CMD, 32'h0000_0001);
    ticks(3);
    rdc("preset cmd", A_POS, 32'h0000_00C8);
    preset_in <= 1'b0;
    apb(1'b1, A_CTRL, 32'h0000_0028);
    ticks(2);
    rdc("quality", A_QUAL, 32'h0000_005A);
    rdc("dist", A_DIST, 32'h0000_0078);
    step <= 32'h0000_03E8;
    ticks(30);
    rdc("vel", A_VEL, 32'h0000_03E8);
    apb(1'b1, A_VRES, 32'h0000_000A);
    ticks(9);
    rdc("vel res", A_VEL, 32'h0000_0064);
    step <= 32'h0000_0000;
    apb(1'b1, A_IRQ_CLR, 32'h0000_000F);
    apb(1'b1, A_IRQ_EN, 32'h0000_0001);
    ticks(1);
    @(negedge pclk);
    chk("irq new", {31'h0, irq}, 32'h0000_0001);
    apb(1'b1, A_IRQ_CLR, 32'h0000_0001);
    @(negedge pclk);
    chk("irq clr", {31'h0, irq}, 32'h0000_0000);
    apb(1'b1, A_IRQ_EN, 32'h0000_0000);
    ticks(1);
    @(negedge pclk);
    chk("irq mask", {31'h0, irq}, 32'h0000_0000);
    rdc("irq st", A_IRQ_ST, 32'h0000_0001);
    // error held for 3 ms, then the substitute value
    apb(1'b1, A_ERRDLY, 32'h0000_0003);
    apb(1'b1, A_ERRVAL, 32'h0000_0077);
    apb(1'b1, A_IRQ_EN, 32'h0000_0004);
    ticks(12);
    apb(1'b0, A_POS, 32'h0000_0000);
    pv = rv;
    ok <= 1'b0;
    ticks(2);
    rdc("stat hold", A_STAT, {29'h0, ST_HOLD});
    rdc("pos hold", A_POS, pv);
    ticks(6);
    rdc("stat subst", A_STAT, {29'h0, ST_SUBST});
    rdc("pos subst", A_POS, 32'h0000_0077);
    rdc("vel subst", A_VEL, 32'h0000_0077);
    @(negedge pclk);
    chk("irq subst", {31'h0, irq}, 32'h0000_0001);
    @(posedge pclk);
    ok <= 1'b1;
    presetn <= 1'b0;
    repeat (2) @(negedge pclk);
    chk("irq rst", {31'h0, irq}, 32'h0000_0000);
    @(posedge pclk);
    presetn <= 1'b1;
    foreach (RA[i]) rdc("reset val", RA[i], RV[i]);
    test_done();
  end
endmodule // position_velocity_processing_tb
